// >>> core/fbc_core.sv
// Purpose: Mode strap, pin decode, serial register port and output gating
// Assumes: All inputs synchronous to clk; input clocks are sampled levels
// Notes: Driver kind 2'b11 means high impedance for that output
`include "fbc_params.svh"

module fbc_core (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Mode strap and factory default
	input wire logic mode_strap,
	input wire logic otp_vcm_default,
	// Select pins, address straps in serial mode
	input wire logic input_choice_bit0,
	input wire logic input_choice_bit1,
	// Type pins, bus clock and data in serial mode
	input wire logic driver_kind_bit0,
	input wire logic driver_kind_bit1_i,
	output logic driver_kind_bit1_o,
	output logic driver_kind_bit1_oe,
	// Per output enables
	input wire logic [7:0] output_enable_low,
	// Sampled input clocks
	input wire logic [3:0] ref_clk_in,
	// Output side
	output logic [7:0] out_clk,
	output logic [7:0] out_drive_en,
	output logic [15:0] out_kind,
	output logic [1:0] src_sel,
	// Analog settings and serial mode flag
	output logic vcm_sel,
	output logic [6:0] xtal_load_cap,
	output logic [2:0] xtal_gain,
	output logic [6:0] xtal_series_sw,
	output logic serial_mode
);
	import fbc_pkg::*;

	logic mode_r;
	logic cap_done_r;
	logic [1:0] insel_r;
	logic [15:0] drv_r;
	logic [7:0] off_r;
	logic [6:0] lcap_r;
	logic [2:0] gain_r;
	logic [6:0] rser_r;
	logic vcm_r;
	logic scl_prev_r;
	logic sda_prev_r;
	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;
	fbc_bus_t bus_r;
	logic [3:0] bit_r;
	logic [7:0] sh_r;
	logic [7:0] tx_r;
	logic [6:0] ptr_r;
	logic ack_r;
	logic wr_go;
	logic [6:0] dev_addr;
	logic [7:0] want;
	logic clk_s;
	logic clk_prev_r;
	logic in_rise;
	logic in_fall;
	fbc_gate_t gate_r [8];
	logic [2:0] cnt_r [8];
	// Register read decode
	function automatic logic [7:0] rd_mux(input logic [6:0] a);
		logic [7:0] d;
		d = 8'h00;
		unique case (a)
			`FBC_A_GAIN: d = {5'h00, gain_r};
			`FBC_A_LCAP: d = {1'b0, lcap_r};
			`FBC_A_INSEL: d = {6'h00, insel_r};
			`FBC_A_DRV0: d = drv_r[7:0];
			`FBC_A_DRV1: d = drv_r[15:8];
			`FBC_A_OFF: d = off_r;
			`FBC_A_VCM: d = {7'h00, vcm_r};
			`FBC_A_RSER: d = {1'b0, rser_r};
			default: d = 8'h00;
		endcase
		return d;
	endfunction

	// Strap and factory default caught once after reset release
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			mode_r <= 1'b0;
			cap_done_r <= 1'b0;
		end else if (!cap_done_r) begin
			mode_r <= mode_strap;
			cap_done_r <= 1'b1;
		end
	end
	assign serial_mode = mode_r;
	// Bus line edge and condition detection
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			scl_prev_r <= 1'b1;
			sda_prev_r <= 1'b1;
		end else begin
			scl_prev_r <= driver_kind_bit0;
			sda_prev_r <= driver_kind_bit1_i;
		end
	end
	assign scl_rise = mode_r && driver_kind_bit0 && !scl_prev_r;
	assign scl_fall = mode_r && !driver_kind_bit0 && scl_prev_r;
	assign bus_start = mode_r && driver_kind_bit0 && scl_prev_r && sda_prev_r
		&& !driver_kind_bit1_i;
	assign bus_stop = mode_r && driver_kind_bit0 && scl_prev_r && !sda_prev_r
		&& driver_kind_bit1_i;
	assign dev_addr = `FBC_BUS_BASE + {5'h00, input_choice_bit1, input_choice_bit0};
	assign wr_go = scl_fall && bus_r == BUS_WR && bit_r == 4'h7;
	// Serial client: address, command byte, data bytes
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			bus_r <= BUS_IDLE;
			bit_r <= 4'h0;
			sh_r <= 8'h00;
			tx_r <= 8'h00;
			ptr_r <= 7'h00;
			ack_r <= 1'b0;
		end else if (bus_start) begin
			bus_r <= BUS_ADDR;
			bit_r <= 4'hf; // SCL fall that closes START wraps this to bit 0
			ack_r <= 1'b0;
		end else if (bus_stop) begin
			bus_r <= BUS_IDLE;
			ack_r <= 1'b0;
		end else if (scl_rise && bit_r != 4'h8) begin
			sh_r <= {sh_r[6:0], driver_kind_bit1_i};
		end else if (scl_rise && bus_r == BUS_RD && driver_kind_bit1_i) begin
			bus_r <= BUS_SKIP; // Host refused more data
		end else if (scl_fall && bit_r == 4'h7) begin
			bit_r <= 4'h8;
			unique case (bus_r)
				BUS_ADDR: ack_r <= sh_r[7:1] == dev_addr;
				BUS_CMD: begin
					ack_r <= 1'b1;
					ptr_r <= sh_r[6:0];
				end
				BUS_WR: begin
					ack_r <= 1'b1;
					ptr_r <= ptr_r + 7'h01;
				end
				default: ack_r <= 1'b0;
			endcase
		end else if (scl_fall && bit_r == 4'h8) begin
			bit_r <= 4'h0;
			ack_r <= 1'b0;
			unique case (bus_r)
				BUS_ADDR: begin
					if (!ack_r) begin
						bus_r <= BUS_SKIP;
					end else if (sh_r[0]) begin
						bus_r <= BUS_RD;
						tx_r <= rd_mux(ptr_r);
					end else begin
						bus_r <= BUS_CMD;
					end
				end
				BUS_CMD: bus_r <= BUS_WR;
				BUS_RD: begin
					ptr_r <= ptr_r + 7'h01;
					tx_r <= rd_mux(ptr_r + 7'h01);
				end
				default: bus_r <= bus_r;
			endcase
		end else if (scl_fall) begin
			bit_r <= bit_r + 4'h1;
			if (bus_r == BUS_RD) begin
				tx_r <= {tx_r[6:0], 1'b0};
			end
		end
	end
	// Open-drain data: low for acknowledge or a zero read bit
	assign driver_kind_bit1_o = 1'b0;
	assign driver_kind_bit1_oe = ack_r
		|| (bus_r == BUS_RD && bit_r != 4'h8 && !tx_r[7]);
	// Writable registers
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			insel_r <= 2'h0;
			drv_r <= 16'h0000;
			off_r <= 8'h00;
			lcap_r <= `FBC_R_LCAP;
			gain_r <= `FBC_R_GAIN;
			rser_r <= `FBC_R_RSER;
			vcm_r <= `FBC_R_VCM;
		end else if (!cap_done_r) begin
			vcm_r <= otp_vcm_default;
		end else if (wr_go) begin
			unique case (ptr_r)
				`FBC_A_GAIN: gain_r <= (sh_r[2:0] > `FBC_GAIN_MAX || sh_r[7:3] != 5'h00)
					? `FBC_GAIN_MAX : sh_r[2:0];
				`FBC_A_LCAP: lcap_r <= (sh_r[6:0] > `FBC_LCAP_MAX || sh_r[7])
					? `FBC_LCAP_MAX : sh_r[6:0];
				`FBC_A_INSEL: insel_r <= sh_r[1:0];
				`FBC_A_DRV0: drv_r[7:0] <= sh_r;
				`FBC_A_DRV1: drv_r[15:8] <= sh_r;
				`FBC_A_OFF: off_r <= sh_r;
				`FBC_A_VCM: vcm_r <= sh_r[0];
				`FBC_A_RSER: rser_r <= sh_r[6:0];
				default: vcm_r <= vcm_r;
			endcase
		end
	end
	// Settings seen by the analog side; in pin mode crystal fixed, select and kind from pins
	always_comb begin
		if (mode_r) begin
			src_sel = insel_r;
			out_kind = drv_r;
			xtal_load_cap = lcap_r;
			xtal_series_sw = rser_r;
			xtal_gain = gain_r;
		end else begin
			src_sel = {input_choice_bit1, input_choice_bit0};
			out_kind = {8{driver_kind_bit1_i, driver_kind_bit0}};
			xtal_load_cap = `FBC_R_LCAP;
			xtal_series_sw = `FBC_R_RSER;
			xtal_gain = `FBC_R_GAIN;
		end
	end
	assign vcm_sel = vcm_r;
	// Wanted output state from pin or register, hi-Z kind forces off
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			want[i] = (mode_r ? !off_r[i] : !output_enable_low[i])
				&& out_kind[2*i +: 2] != 2'b11;
		end
	end
	// Selected input clock and its edges
	assign clk_s = ref_clk_in[src_sel];
	assign in_rise = clk_s && !clk_prev_r;
	assign in_fall = !clk_s && clk_prev_r;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			clk_prev_r <= 1'b0;
		end else begin
			clk_prev_r <= clk_s;
		end
	end
	// Output gating sequenced on the selected input clock
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < 8; i++) begin
				gate_r[i] <= G_OFF;
				cnt_r[i] <= 3'h0;
			end
			out_drive_en <= 8'h00;
			out_clk <= 8'h00;
		end else begin
			for (int i = 0; i < 8; i++) begin
				unique case (gate_r[i])
					G_OFF: if (want[i]) begin
						gate_r[i] <= G_LOW;
						cnt_r[i] <= 3'h0;
						out_drive_en[i] <= 1'b1;
					end
					G_LOW: if (!want[i]) begin
						gate_r[i] <= G_OFF;
						out_drive_en[i] <= 1'b0;
					end else if (in_rise) begin
						cnt_r[i] <= cnt_r[i] + 3'h1;
						if (cnt_r[i] == `FBC_FOLLOW_EDGES - 3'h1) begin
							gate_r[i] <= G_RUN;
						end
					end
					G_RUN: if (!want[i] && in_fall) begin
						gate_r[i] <= G_OFF;
						out_drive_en[i] <= 1'b0;
					end
				endcase
				out_clk[i] <= gate_r[i] == G_RUN && clk_s;
			end
		end
	end
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	logic [2:0] dis_edges_r;
	logic [2:0] en_edges_r;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			dis_edges_r <= 3'h0;
			en_edges_r <= 3'h0;
		end else begin
			dis_edges_r <= (want[0] || !out_drive_en[0]) ? 3'h0
				: dis_edges_r + {2'h0, in_rise};
			en_edges_r <= (!want[0] || gate_r[0] != G_LOW) ? 3'h0
				: en_edges_r + {2'h0, in_rise};
		end
	end

	sequence s_ask_on;
		!want[0] ##1 want[0] && gate_r[0] == G_OFF;
	endsequence
	sequence s_low_drive;
		out_drive_en[0] && !out_clk[0];
	endsequence

	property p_src_pin;
		cap_done_r && !mode_r |-> src_sel == {input_choice_bit1, input_choice_bit0};
	endproperty
	a_src_pin: assert property (p_src_pin) else $error("Pin select not routed");
	property p_kind_hiz;
		cap_done_r && !mode_r && driver_kind_bit1_i && driver_kind_bit0 && in_fall
			|=> out_drive_en == 8'h00;
	endproperty
	a_kind_hiz: assert property (p_kind_hiz) else $error("Outputs driven in hi-Z kind");
	property p_enable_low;
		s_ask_on |=> s_low_drive;
	endproperty
	a_enable_low: assert property (p_enable_low) else $error("Enable not static low");
	property p_strap_hold;
		cap_done_r |=> $stable(mode_r);
	endproperty
	a_strap_hold: assert property (p_strap_hold) else $error("Mode changed after capture");
	property p_addr;
		dev_addr == 7'h34 + {5'h00, input_choice_bit1, input_choice_bit0};
	endproperty
	a_addr: assert property (p_addr) else $error("Bus address wrong");
	property p_pin_xtal;
		!mode_r |-> xtal_load_cap == 7'h10 && xtal_series_sw == 7'h10;
	endproperty
	a_pin_xtal: assert property (p_pin_xtal) else $error("Pin mode crystal not fixed");
	property p_dis_bound;
		dis_edges_r <= 3'h5;
	endproperty
	a_dis_bound: assert property (p_dis_bound) else $error("Disable took over 5 periods");
	property p_en_bound;
		en_edges_r <= 3'h5;
	endproperty
	a_en_bound: assert property (p_en_bound) else $error("Follow took over 5 periods");
	property p_vcm_fall;
		cap_done_r && $past(cap_done_r) && $fell(vcm_r) |-> $past(wr_go)
			&& $past(ptr_r) == 7'h0c && !$past(sh_r[0]);
	endproperty
	a_vcm_fall: assert property (p_vcm_fall) else $error("Common mode cleared unasked");
	property p_fanout;
		out_clk[0] |-> $past(clk_s) && $past(gate_r[0] == G_RUN);
	endproperty
	a_fanout: assert property (p_fanout) else $error("Output not from selected input");
endmodule

// >>> common/fbc_params.svh
// Purpose: Offsets, reset values and timing counts of the fanout control block
// Assumes: Included by bare name after the package
// Notes: Register offsets are serial bus register addresses
`ifndef FBC_PARAMS_SVH
`define FBC_PARAMS_SVH
// Register addresses
`define FBC_A_GAIN 7'h00
`define FBC_A_LCAP 7'h02
`define FBC_A_INSEL 7'h05
`define FBC_A_DRV0 7'h07
`define FBC_A_DRV1 7'h08
`define FBC_A_OFF 7'h0a
`define FBC_A_VCM 7'h0c
`define FBC_A_RSER 7'h12
// Reset and fixed values
`define FBC_R_GAIN 3'h2
`define FBC_GAIN_MAX 3'h4
`define FBC_R_LCAP 7'h10
`define FBC_LCAP_MAX 7'h57
`define FBC_R_RSER 7'h10
`define FBC_RSER_MIN 7'h7f
`define FBC_R_VCM 1'b1
`define FBC_BUS_BASE 7'h34
// Sequencing counts in selected input clock periods
`define FBC_EDGE_MAX 3'h5
`define FBC_FOLLOW_EDGES 3'h2
`endif

// >>> common/fbc_pkg.sv
// Purpose: Types of the fanout control block
// Assumes: Nothing
// Notes: Constants live in fbc_params.svh
package fbc_pkg;
	typedef enum logic [2:0] {BUS_IDLE, BUS_ADDR, BUS_CMD, BUS_WR, BUS_RD, BUS_SKIP} fbc_bus_t;
	typedef enum logic [1:0] {G_OFF, G_LOW, G_RUN} fbc_gate_t;
	typedef logic [1:0] fbc_drv_t;
endpackage

// >>> verification/fbc_host.sv
// Purpose: Serial bus host model for the fanout control block
// Assumes: Bus lines sampled by the block on clk; SDA has a pull-up
// Notes: Every bus phase lasts 4 clk; lines change 1 ns after an edge
module fbc_host (
	// Clock
	input wire logic clk,
	// Bus lines driven by the host, 1 on sda means released
	output logic scl,
	output logic sda,
	// Resolved data line level
	input wire logic sda_line
);
	timeunit 1ns;
	timeprecision 100ps;
	// One bus phase
	task automatic ph();
		repeat (4) @(posedge clk);
		#1;
	endtask
	// Start or repeated start
	task automatic start();
		sda = 1'b1;
		ph();
		scl = 1'b1;
		ph();
		sda = 1'b0;
		ph();
		scl = 1'b0;
	endtask
	// Stop condition
	task automatic stop();
		sda = 1'b0;
		ph();
		scl = 1'b1;
		ph();
		sda = 1'b1;
		ph();
	endtask
	// Eight bits MSB first then the acknowledge slot; q holds what the line showed
	task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] q,
		output logic ack_hi);
		for (int i = 7; i >= -1; i--) begin
			sda = (i < 0) ? mack : d[i];
			ph();
			scl = 1'b1;
			ph();
			if (i < 0) begin
				ack_hi = sda_line;
			end else begin
				q[i] = sda_line;
			end
			scl = 1'b0;
		end
	endtask
	// Register write; ok is high when all three bytes were acknowledged
	task automatic wr(input logic [6:0] dev, input logic [6:0] ra, input logic [7:0] d,
		output logic ok);
		logic [7:0] q;
		logic a0, a1, a2;
		start();
		xfer({dev, 1'b0}, 1'b1, q, a0);
		xfer({1'b1, ra}, 1'b1, q, a1);
		xfer(d, 1'b1, q, a2);
		stop();
		ok = ~a0 & ~a1 & ~a2;
	endtask
	// Register read with repeated start and a closing not-acknowledge
	task automatic rd(input logic [6:0] dev, input logic [6:0] ra, output logic [7:0] q);
		logic [7:0] x;
		logic a;
		start();
		xfer({dev, 1'b0}, 1'b1, x, a);
		xfer({1'b1, ra}, 1'b1, x, a);
		start();
		xfer({dev, 1'b1}, 1'b1, x, a);
		xfer(8'hff, 1'b1, q, a);
		stop();
	endtask
	// Bus idle with both lines released
	initial begin
		scl = 1'b1;
		sda = 1'b1;
	end
endmodule

// >>> verification/fbc_core_test.sv
// Purpose: Self-checking bench for the fanout control block
// Assumes: Strap is stable except where a scenario flips it on purpose
// Notes: Input clocks are divided from clk, input k toggles every k+2 cycles
module fbc_core_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk, rstn, strap, otp, ser, scl, sda, k0, k1, sda_o, sda_oe, ok;
	logic [1:0] isel, pk, src_sel;
	logic [7:0] oel, out_clk, out_en, q;
	logic [3:0] ref_clk;
	logic [15:0] out_kind;
	logic vcm_sel, serial_mode;
	logic [6:0] lcap, rser;
	logic [2:0] gain;
	int err_count, checks, cyc, rc, n;
	// Type pins carry the bus in serial mode; SDA is pulled up
	assign k0 = ser ? scl : pk[0];
	assign k1 = ser ? (sda & ~(sda_oe & ~sda_o)) : pk[1];
	fbc_core dut_u (.clk(clk), .rstn(rstn), .mode_strap(strap), .otp_vcm_default(otp),
		.input_choice_bit0(isel[0]), .input_choice_bit1(isel[1]), .driver_kind_bit0(k0),
		.driver_kind_bit1_i(k1), .driver_kind_bit1_o(sda_o), .driver_kind_bit1_oe(sda_oe),
		.output_enable_low(oel), .ref_clk_in(ref_clk), .out_clk(out_clk),
		.out_drive_en(out_en), .out_kind(out_kind), .src_sel(src_sel), .vcm_sel(vcm_sel),
		.xtal_load_cap(lcap), .xtal_gain(gain), .xtal_series_sw(rser),
		.serial_mode(serial_mode));
	fbc_host h_u (.clk(clk), .scl(scl), .sda(sda), .sda_line(k1));
	// Clock
	always #5 clk = ~clk;
	// Input clocks and hang guard
	always @(posedge clk) begin
		#1;
		rc++;
		cyc++;
		for (int k = 0; k < 4; k++) begin
			if (rc % (k + 2) == 0) begin
				ref_clk[k] = ~ref_clk[k];
			end
		end
		if (cyc == 50000) begin
			err_count++;
			results();
		end
	end
	task automatic step(input int c);
		repeat (c) @(posedge clk);
		#1;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rst(input logic s, input logic o);
		rstn = 1'b0;
		strap = s;
		otp = o;
		step(12);
		rstn = 1'b1;
		step(3);
	endtask
	// Pin decode and fixed crystal settings
	task automatic t_pin();
		rst(1'b0, 1'b0);
		chk(vcm_sel, 1'b0);
		chk(serial_mode, 1'b0);
		for (int c = 0; c < 4; c++) begin
			isel = c[1:0];
			pk = c[1:0];
			step(1);
			chk(src_sel, c[1:0]);
			chk(out_kind, {8{c[1:0]}});
		end
		chk(lcap, 7'h10);
		chk(rser, 7'h10);
	endtask
	// Enable sequencing of one output, then fanout of all and disable of all
	task automatic t_gate();
		logic lvl;
		isel = 2'h0;
		pk = 2'h0;
		step(4);
		oel[3] = 1'b0;
		step(1);
		chk(out_en, 8'h08);
		chk(out_clk[3], 1'b0);
		for (n = 0; n < 20 && out_clk[3] !== 1'b1; n++) step(1);
		chk(n < 20, 1'b1);
		oel = 8'h00;
		step(30);
		// Input level taken mid-cycle, before the block samples it
		for (int i = 0; i < 8; i++) begin
			@(negedge clk);
			lvl = ref_clk[0];
			step(1);
			chk(out_clk, {8{lvl}});
		end
		// Type pins at 11 take every output off, then back on
		pk = 2'h3;
		for (n = 0; n < 20 && out_en !== 8'h00; n++) step(1);
		chk(out_en, 8'h00);
		pk = 2'h0;
		step(12);
		chk(out_en, 8'hff);
		oel = 8'hff;
		for (n = 0; n < 20 && out_en !== 8'h00; n++) step(1);
		chk(n < 20, 1'b1);
		chk(out_en, 8'h00);
	endtask
	// Serial control: address straps, register writes and reads
	task automatic t_ser();
		ser = 1'b1;
		isel = 2'h2;
		rst(1'b1, 1'b1);
		strap = 1'b0;
		step(4);
		chk(serial_mode, 1'b1);
		chk(vcm_sel, 1'b1);
		h_u.wr(7'h34, 7'h0c, 8'h00, ok);
		chk(ok, 1'b0);
		chk(vcm_sel, 1'b1);
		h_u.wr(7'h36, 7'h0c, 8'h00, ok);
		chk(ok, 1'b1);
		chk(vcm_sel, 1'b0);
		h_u.wr(7'h36, 7'h00, 8'h07, ok);
		chk(gain, 3'h4);
		h_u.wr(7'h36, 7'h02, 8'h57, ok);
		h_u.rd(7'h36, 7'h02, q);
		chk(q, 8'h57);
		h_u.wr(7'h36, 7'h12, 8'h7f, ok);
		chk(rser, 7'h7f);
		h_u.wr(7'h36, 7'h07, 8'he4, ok);
		chk(out_kind[7:0], 8'he4);
	endtask
	task automatic results();
		$display("errors=%0d checks=%0d", err_count, checks);
		if (err_count == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		rstn = 1'b0;
		strap = 1'b0;
		otp = 1'b0;
		ser = 1'b0;
		isel = 2'h0;
		pk = 2'h0;
		oel = 8'hff;
		ref_clk = 4'h0;
		t_pin();
		t_gate();
		t_ser();
		results();
	end
endmodule
